//--- rtl/ale_exec.sv
// Execution unit for auto-indexed memory moves, word move, multiply, next
// ==========================================================
// What this block does
// - Load post-dec reads the byte at the pair, then lowers the pair.
// - Load post-inc reads the byte at the pair, then raises the pair.
// - Store pre-dec lowers the pair by one, then writes the source byte.
// - Store pre-inc raises the pair by one, then writes the source byte.
// - The first variant goes to program memory, the second to data memory.
// - An even pair field selects program memory, an odd one data memory.
// - Memory moves, the word move and the next step keep every flag.
// - Moves keep the source; only destination and pointer change.
// - The word move copies the 16-bit source to the destination as a unit.
// - Multiply puts the even register byte times a source byte in the pair.
// - Both multiply operands are unsigned.
// - Multiply sets carry when the product exceeds 255, else clears it.
// - Multiply sets zero and sign, clears overflow, keeps D and H.
// - Next loads the PC with the word at the pointer, then steps it by 2.
`timescale 1ns/1ps
`include "ale_consts.svh"
`default_nettype none
module ale_exec
  import ale_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output logic mem_we,
  output logic mem_prog,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  // ==========================================================
  // Bus address phase capture
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  wire bus_go = hsel & hready & htrans[1];
  wire rd_go = bus_go & ~hwrite;
  wire wr_go = bus_go & hwrite;

  // ==========================================================
  // Architectural state seen through registers
  logic [15:0] ptr_ff;
  logic [15:0] iptr_ff;
  logic [15:0] pc_ff;
  logic [15:0] opa_ff;
  logic [7:0] opb_ff;
  logic [15:0] res_ff;
  logic [7:0] flags_ff;
  logic [3:0] op_ff;
  logic sel_ff;
  logic [7:0] nhi_ff;
  ale_state_e st_ff;
  ale_state_e nxt_st;

  wire busy = (st_ff != ALE_ST_IDLE);
  wire wr_cmd = wr_pend_ff & (wr_addr_ff == `ALE_OFF_CMD);
  wire wr_ptr = wr_pend_ff & (wr_addr_ff == `ALE_OFF_PTR) & ~busy;
  wire wr_iptr = wr_pend_ff & (wr_addr_ff == `ALE_OFF_IPTR) & ~busy;
  wire wr_pc = wr_pend_ff & (wr_addr_ff == `ALE_OFF_PC) & ~busy;
  wire wr_opa = wr_pend_ff & (wr_addr_ff == `ALE_OFF_OPA) & ~busy;
  wire wr_opb = wr_pend_ff & (wr_addr_ff == `ALE_OFF_OPB) & ~busy;
  wire wr_flg = wr_pend_ff & (wr_addr_ff == `ALE_OFF_FLAGS) & ~busy;
  wire [3:0] cmd_op = hwdata[`ALE_CMD_OP_MSB:`ALE_CMD_OP_LSB];
  wire start = wr_cmd & ~busy & (cmd_op <= 4'h6);

  // ==========================================================
  // Operation decode
  wire is_mem = (op_ff <= 4'h3);
  wire is_store = (op_ff == ALE_OP_STORE_PRE_DEC) |
                  (op_ff == ALE_OP_STORE_PRE_INC);
  wire step_down = (op_ff == ALE_OP_LOAD_POST_DEC) |
                   (op_ff == ALE_OP_STORE_PRE_DEC);
  wire is_next = (op_ff == ALE_OP_NEXT);
  // Odd pair field means data memory
  wire prog_space = ~sel_ff;

  // ==========================================================
  // Pointer stepper shared by memory moves and next
  logic [15:0] step_in;
  logic [15:0] stepped;
  wire [2:0] step_amt = is_next ? 3'h2 : 3'h1;
  assign step_in = is_next ? iptr_ff : ptr_ff;
  ale_ptr_step u_step (
    .ptr(step_in),
    .step(step_amt),
    .down(step_down & ~is_next),
    .stepped(stepped)
  );

  // ==========================================================
  // Unsigned multiply of even register byte by 8-bit source
  wire [15:0] product = {8'h00, opa_ff[15:8]} * {8'h00, opb_ff};
  wire prod_c = (product > 16'h00FF);
  wire prod_z = (product == 16'h0000);
  wire prod_s = product[15];

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ALE_ST_IDLE: begin
        if (start) begin
          nxt_st = ALE_ST_ADJ;
        end
      end
      ALE_ST_ADJ: begin
        if (is_next) begin
          nxt_st = ALE_ST_NXT_HI;
        end else if (is_mem) begin
          nxt_st = ALE_ST_MEM;
        end else begin
          nxt_st = ALE_ST_IDLE;
        end
      end
      ALE_ST_MEM: begin
        if (mem_ack) begin
          nxt_st = ALE_ST_IDLE;
        end
      end
      ALE_ST_NXT_HI: begin
        if (mem_ack) begin
          nxt_st = ALE_ST_NXT_LO;
        end
      end
      ALE_ST_NXT_LO: begin
        if (mem_ack) begin
          nxt_st = ALE_ST_IDLE;
        end
      end
      default: nxt_st = ALE_ST_IDLE;
    endcase
  end

  // Memory port: stores use the pointer already stepped in ADJ
  assign mem_req = (st_ff == ALE_ST_MEM) | (st_ff == ALE_ST_NXT_HI) |
                   (st_ff == ALE_ST_NXT_LO);
  assign mem_we = (st_ff == ALE_ST_MEM) & is_store;
  assign mem_prog = is_next | prog_space;
  assign mem_addr = (st_ff == ALE_ST_NXT_LO) ? iptr_ff + 16'h0001 :
                    (st_ff == ALE_ST_NXT_HI) ? iptr_ff : ptr_ff;
  assign mem_wdata = opb_ff;

  // ==========================================================
  // State and command capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ALE_ST_IDLE;
      op_ff <= 4'h0;
      sel_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (start) begin
        op_ff <= cmd_op;
        sel_ff <= hwdata[`ALE_CMD_SEL_BIT];
      end
    end
  end

  // Pointer: stores step first, loads step after the read completes
  wire ptr_pre = (st_ff == ALE_ST_ADJ) & is_store;
  wire ptr_post = (st_ff == ALE_ST_MEM) & mem_ack & ~is_store;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_ff <= `ALE_RST_PTR;
    end else if (ptr_pre | ptr_post) begin
      ptr_ff <= stepped;
    end else if (wr_ptr) begin
      ptr_ff <= hwdata[15:0];
    end
  end

  // Next: high byte first, then low byte, then step by two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iptr_ff <= `ALE_RST_IPTR;
      pc_ff <= `ALE_RST_PC;
      nhi_ff <= 8'h00;
    end else begin
      if ((st_ff == ALE_ST_NXT_HI) & mem_ack) begin
        nhi_ff <= mem_rdata;
      end
      if ((st_ff == ALE_ST_NXT_LO) & mem_ack) begin
        pc_ff <= {nhi_ff, mem_rdata};
        iptr_ff <= stepped;
      end else if (wr_iptr) begin
        iptr_ff <= hwdata[15:0];
      end
      if (wr_pc) begin
        pc_ff <= hwdata[15:0];
      end
    end
  end

  // Operands are only written by software, never by execution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_ff <= 16'h0000;
      opb_ff <= 8'h00;
    end else begin
      if (wr_opa) begin
        opa_ff <= hwdata[15:0];
      end
      if (wr_opb) begin
        opb_ff <= hwdata[7:0];
      end
    end
  end

  // Result register: loaded byte, moved word or product
  wire do_mul = (st_ff == ALE_ST_ADJ) & (op_ff == ALE_OP_UNSIGNED_MULTIPLY);
  wire do_mov = (st_ff == ALE_ST_ADJ) & (op_ff == ALE_OP_WORD_MOVE);
  wire do_ld = (st_ff == ALE_ST_MEM) & mem_ack & ~is_store;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_ff <= 16'h0000;
    end else if (do_mul) begin
      res_ff <= product;
    end else if (do_mov) begin
      res_ff <= opa_ff;
    end else if (do_ld) begin
      res_ff <= {8'h00, mem_rdata};
    end
  end

  // Flags change only on multiply or a flags write; D and H are never touched by multiply
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= `ALE_RST_FLAGS;
    end else if (do_mul) begin
      flags_ff[`ALE_FLG_C] <= prod_c;
      flags_ff[`ALE_FLG_Z] <= prod_z;
      flags_ff[`ALE_FLG_S] <= prod_s;
      flags_ff[`ALE_FLG_V] <= 1'b0;
    end else if (wr_flg) begin
      flags_ff <= hwdata[7:0];
    end
  end

  // ==========================================================
  // Bus slave: always ready, always OKAY, reads registered
  logic [31:0] rd_mux;
  always_comb begin
    unique case (haddr)
      `ALE_OFF_STAT: rd_mux = {27'h0000000, st_ff};
      `ALE_OFF_PTR: rd_mux = {16'h0000, ptr_ff};
      `ALE_OFF_IPTR: rd_mux = {16'h0000, iptr_ff};
      `ALE_OFF_PC: rd_mux = {16'h0000, pc_ff};
      `ALE_OFF_OPA: rd_mux = {16'h0000, opa_ff};
      `ALE_OFF_OPB: rd_mux = {24'h000000, opb_ff};
      `ALE_OFF_RES: rd_mux = {16'h0000, res_ff};
      `ALE_OFF_FLAGS: rd_mux = {24'h000000, flags_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= wr_go;
      if (wr_go) begin
        wr_addr_ff <= haddr;
      end
      if (rd_go) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Checks
  wire mem_done = (st_ff == ALE_ST_MEM) & mem_ack;

  load_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ALE_ST_ADJ) & is_mem & ~is_store |=> $stable(ptr_ff))
    else $error("load pointer stepped before read");

  // Expected step worked out here, not taken from the shared stepper
  load_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_done & ~is_store |=> ptr_ff == ($past(step_down) ?
      $past(ptr_ff) - 16'h0001 : $past(ptr_ff) + 16'h0001))
    else $error("load pointer not stepped after read");

  store_pre_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ALE_ST_ADJ) & is_store & step_down
    |=> ptr_ff == $past(ptr_ff) - 16'h0001)
    else $error("pre-decrement wrong");

  store_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ALE_ST_ADJ) & is_store & ~step_down
    |=> ptr_ff == $past(ptr_ff) + 16'h0001)
    else $error("pre-increment wrong");

  space_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ALE_ST_MEM) |-> mem_prog == ~sel_ff)
    else $error("memory space wrong");

  flags_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    busy & (op_ff != ALE_OP_UNSIGNED_MULTIPLY) |=> $stable(flags_ff))
    else $error("flags changed");

  mul_carry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_mul |=> flags_ff[`ALE_FLG_C] == (res_ff > 16'h00FF)
      && !flags_ff[`ALE_FLG_V])
    else $error("multiply carry wrong");

  mul_dh_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_mul |=> flags_ff[3:2] == $past(flags_ff[3:2])
      && flags_ff[`ALE_FLG_Z] == (res_ff == 16'h0000)
      && flags_ff[`ALE_FLG_S] == res_ff[15])
    else $error("multiply D/H, zero or sign wrong");

  next_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ALE_ST_NXT_LO) & mem_ack
    |=> iptr_ff == $past(iptr_ff) + 16'h0002)
    else $error("next step wrong");

  src_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    busy |=> $stable(opb_ff) && $stable(opa_ff))
    else $error("source altered");

  cov_store: cover property (@(posedge hclk) mem_req & mem_we & mem_ack);
  cov_load: cover property (@(posedge hclk) mem_done & ~mem_we);
  cov_mul: cover property (@(posedge hclk) do_mul & prod_c);
  cov_next: cover property (@(posedge hclk)
    (st_ff == ALE_ST_NXT_LO) & mem_ack);
endmodule
`default_nettype wire

//--- rtl/ale_consts.svh
// Constants of the auto-index load, multiply and next execution unit
`ifndef ALE_CONSTS_SVH
`define ALE_CONSTS_SVH

// ==========================================================
// Register map, byte addresses on the bus
`define ALE_OFF_CMD 12'h000
`define ALE_OFF_STAT 12'h004
`define ALE_OFF_PTR 12'h008
`define ALE_OFF_IPTR 12'h00C
`define ALE_OFF_PC 12'h010
`define ALE_OFF_OPA 12'h014
`define ALE_OFF_OPB 12'h018
`define ALE_OFF_RES 12'h01C
`define ALE_OFF_FLAGS 12'h020

// ==========================================================
// Command register fields
`define ALE_CMD_OP_LSB 0
`define ALE_CMD_OP_MSB 3
`define ALE_CMD_SEL_BIT 4

// ==========================================================
// Flag register bit positions
`define ALE_FLG_C 7
`define ALE_FLG_Z 6
`define ALE_FLG_S 5
`define ALE_FLG_V 4
`define ALE_FLG_D 3
`define ALE_FLG_H 2

// ==========================================================
// Reset values
`define ALE_RST_PTR 16'h0000
`define ALE_RST_IPTR 16'h0000
`define ALE_RST_PC 16'h0000
`define ALE_RST_FLAGS 8'h00

`endif

//--- rtl/ale_pkg.sv
// Types of the auto-index load, multiply and next execution unit
package ale_pkg;
  typedef enum logic [3:0] {
    ALE_OP_LOAD_POST_DEC = 4'h0,
    ALE_OP_LOAD_POST_INC = 4'h1,
    ALE_OP_STORE_PRE_DEC = 4'h2,
    ALE_OP_STORE_PRE_INC = 4'h3,
    ALE_OP_WORD_MOVE = 4'h4,
    ALE_OP_UNSIGNED_MULTIPLY = 4'h5,
    ALE_OP_NEXT = 4'h6
  } ale_op_e;

  typedef enum logic [4:0] {
    ALE_ST_IDLE = 5'b00001,
    ALE_ST_ADJ = 5'b00010,
    ALE_ST_MEM = 5'b00100,
    ALE_ST_NXT_HI = 5'b01000,
    ALE_ST_NXT_LO = 5'b10000
  } ale_state_e;
endpackage

//--- rtl/ale_ptr_step.sv
// 16-bit pointer stepper that treats a register pair as one value
`timescale 1ns/1ps
`default_nettype none
module ale_ptr_step (
  input wire logic [15:0] ptr,
  input wire logic [2:0] step,
  input wire logic down,
  output logic [15:0] stepped
);
  // Whole-word add keeps carry and borrow crossing between the two bytes
  wire [15:0] step_wide = {13'h0000, step};
  assign stepped = down ? ptr - step_wide : ptr + step_wide;
endmodule
`default_nettype wire

//--- tb/ale_mem_model.sv
// Behavioural program and data memory behind the execution unit
`timescale 1ns/1ps
`default_nettype none
module ale_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic prog,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] lag,
  output logic ack,
  output logic [7:0] rdata,
  output logic [15:0] last_addr,
  output logic [7:0] last_wdata,
  output logic last_prog
);
  logic [1:0] cnt_ff;
  // ==========================================================
  // Access engine
  // Answers after lag waiting cycles; read data toggles when not valid,
  // so a design that samples it an odd number of cycles late sees the byte inverted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt_ff <= 2'h0;
      rdata <= 8'h00;
    end else if (req && !ack && cnt_ff == lag) begin
      ack <= 1'b1;
      cnt_ff <= 2'h0;
      rdata <= addr[7:0] ^ addr[15:8] ^ (prog ? 8'hC3 : 8'h3C);
      last_addr <= addr;
      last_prog <= prog;
      if (we) last_wdata <= wdata;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the execution unit and its memory model
`timescale 1ns/1ps
`include "ale_consts.svh"
`default_nettype none
module tb_top;
  import ale_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans, lag;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic mem_req, mem_we, mem_prog, mem_ack, l_prog;
  logic [15:0] mem_addr, l_addr;
  logic [7:0] mem_wdata, mem_rdata, l_wdata;
  int err_count = 0;
  int checks_done = 0;
  // ==========================================================
  // Design, memory and clock
  assign hready = hreadyout;
  ale_exec ale_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_we(mem_we), .mem_prog(mem_prog), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ale_mem_model ale_mem_model_inst (.clk(hclk), .rst_n(hresetn),
    .req(mem_req), .we(mem_we), .prog(mem_prog), .addr(mem_addr),
    .wdata(mem_wdata), .lag(lag), .ack(mem_ack), .rdata(mem_rdata),
    .last_addr(l_addr), .last_wdata(l_wdata), .last_prog(l_prog));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ==========================================================
  // Checking and closing
  function automatic logic [7:0] pat(logic [15:0] a, logic p);
    return a[7:0] ^ a[15:8] ^ (p ? 8'hC3 : 8'h3C);
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Bus master: address phase held until hready, then data phase
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    // No wait count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Start an operation and poll until the unit is idle again
  task automatic run_op(logic [4:0] cmd);
    logic [31:0] s;
    int n;
    wr(`ALE_OFF_CMD, {27'h0, cmd});
    n = 0;
    do begin
      rd(`ALE_OFF_STAT, s);
      n++;
    end while (s !== 32'h1 && n < 40);
    chk("stat idle", s, 32'h1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    rd(`ALE_OFF_PTR, q);
    chk("ptr rst", q, 32'h0);
    rd(`ALE_OFF_IPTR, q);
    chk("iptr rst", q, 32'h0);
    rd(`ALE_OFF_FLAGS, q);
    chk("flags rst", q, 32'h0);
    rd(12'h040, q);
    chk("unmapped", q, 32'h0);
    wr(`ALE_OFF_CMD, 32'h7);
    rd(`ALE_OFF_STAT, q);
    chk("bad op", q, 32'h1);
  endtask
  // Loads at pointer carry boundaries, both spaces, fast and slow memory
  task automatic t_load();
    logic [31:0] q;
    logic [15:0] p;
    for (int i = 0; i < 4; i++) begin
      p = i[0] ? 16'h10FF : 16'h1000;
      lag <= i[1:0];
      wr(`ALE_OFF_PTR, {16'h0, p});
      wr(`ALE_OFF_FLAGS, 32'hFC);
      run_op({i[1], 3'h0, i[0]});
      rd(`ALE_OFF_RES, q);
      chk("load byte", q, {24'h0, pat(p, !i[1])});
      chk("load addr", l_addr, p);
      rd(`ALE_OFF_PTR, q);
      chk("load ptr", q, i[0] ? p + 1 : p - 1);
      chk("load space", l_prog, !i[1]);
      rd(`ALE_OFF_FLAGS, q);
      chk("load flags", q, 32'hFC);
    end
  endtask
  task automatic t_store();
    logic [31:0] q;
    logic [15:0] p, np;
    for (int i = 0; i < 4; i++) begin
      p = i[0] ? 16'h21FF : 16'h3000;
      np = i[0] ? p + 1 : p - 1;
      lag <= 2'(3 - i);
      wr(`ALE_OFF_PTR, {16'h0, p});
      wr(`ALE_OFF_OPB, 32'h70 + i);
      run_op({i[1], 3'h1, i[0]});
      chk("store addr", l_addr, np);
      chk("store byte", l_wdata, 8'h70 + i);
      chk("store space", l_prog, !i[1]);
      rd(`ALE_OFF_PTR, q);
      chk("store ptr", q, np);
      rd(`ALE_OFF_OPB, q);
      chk("store src", q, 32'h70 + i);
      rd(`ALE_OFF_FLAGS, q);
      chk("store flags", q, 32'hFC);
    end
  endtask
  task automatic t_move();
    logic [31:0] q;
    wr(`ALE_OFF_FLAGS, 32'hFC);
    wr(`ALE_OFF_OPA, 32'h061C);
    run_op(5'h04);
    rd(`ALE_OFF_RES, q);
    chk("move res", q, 32'h061C);
    rd(`ALE_OFF_OPA, q);
    chk("move src", q, 32'h061C);
    rd(`ALE_OFF_FLAGS, q);
    chk("move flags", q, 32'hFC);
  endtask
  // Products around zero, 255 and the top bit; flags preset both ways
  task automatic t_unsigned_multiply();
    logic [7:0] ta[6] = '{8'h20, 8'h20, 8'h00, 8'hFF, 8'h10, 8'h0F};
    logic [7:0] tb[6] = '{8'h09, 8'h03, 8'h55, 8'hFF, 8'h10, 8'h11};
    logic [31:0] q;
    logic [15:0] pr;
    logic [7:0] pre;
    for (int i = 0; i < 6; i++) begin
      pr = ta[i] * tb[i];
      pre = i[0] ? 8'hFC : 8'h00;
      wr(`ALE_OFF_FLAGS, {24'h0, pre});
      wr(`ALE_OFF_OPA, {16'h0, ta[i], 8'hEE});
      wr(`ALE_OFF_OPB, {24'h0, tb[i]});
      run_op(5'h05);
      rd(`ALE_OFF_RES, q);
      chk("product", q, {16'h0, pr});
      rd(`ALE_OFF_FLAGS, q);
      chk("mul c", q[7], pr > 16'd255);
      chk("mul zsv", q[6:4], {pr == 16'h0000, pr[15], 1'b0});
      chk("mul dh", q[3:0], {pre[3:2], 2'b00});
    end
  endtask
  // Next reads the high byte first; flags preset since multiply moved them
  task automatic t_next();
    logic [31:0] q;
    logic [15:0] w;
    w = {pat(16'h12FF, 1'b1), pat(16'h1300, 1'b1)};
    lag <= 2'h2;
    wr(`ALE_OFF_FLAGS, 32'hFC);
    wr(`ALE_OFF_IPTR, 32'h12FF);
    run_op(5'h06);
    rd(`ALE_OFF_PC, q);
    chk("next pc", q, {16'h0, w});
    chk("next addr", l_addr, 16'h1300);
    rd(`ALE_OFF_IPTR, q);
    chk("next iptr", q, 32'h1301);
    chk("next space", l_prog, 1'b1);
    rd(`ALE_OFF_FLAGS, q);
    chk("next flags", q, 32'hFC);
  endtask
  // ==========================================================
  // Main sequence and watchdog (a full run needs about 400 cycles)
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lag = 2'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_load();
    t_store();
    t_move();
    t_unsigned_multiply();
    t_next();
    chk("hresp", hresp, 1'b0);
    finish_test();
  end
  initial begin
    #800000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
